// ---- rtl/pbf_pkg.sv ----
// Constants, types and decode function for the port B upper pin mux
package pbf_pkg;
   localparam int PBF_NPINS = 8;
   localparam int PBF_DW = 16;
   localparam int PBF_FIELD_W = 2;
   localparam int PBF_OFS_W = 4;
   localparam int PBF_NIRQ = 4;
   localparam int PBF_NCH = 2;
   // Register offsets
   localparam logic [3:0] PBF_OFS_FSEL = 4'h0;
   localparam logic [3:0] PBF_OFS_LEVEL = 4'h2;
   // Values after reset
   localparam logic [15:0] PBF_FSEL_RST = 16'h0000;
   localparam logic [7:0] PBF_OE_B_RST = 8'hFF;
   localparam logic [7:0] PBF_PIN_RST = 8'h00;
   localparam logic [3:0] PBF_IRQ_RST = 4'hF;
   localparam logic [1:0] PBF_RX_RST = 2'h3;
   localparam logic [1:0] PBF_SCK_RST = 2'h0;
   localparam logic [15:0] PBF_RDATA_RST = 16'h0000;
   // Field codes
   localparam logic [1:0] PBF_CODE_GPIO = 2'h0;
   localparam logic [1:0] PBF_CODE_ALT1 = 2'h1;
   localparam logic [1:0] PBF_CODE_ALT2 = 2'h2;
   localparam logic [1:0] PBF_CODE_TP = 2'h3;
   // Pin index of the lowest interrupt pin and the lowest reserved-10 pin
   localparam int PBF_IRQ_BASE = 4;
   localparam int PBF_RSV2_BASE = 6;

   typedef enum logic [2:0]
   {
      PBF_FN_GPIO,
      PBF_FN_IRQ,
      PBF_FN_SCK,
      PBF_FN_TX,
      PBF_FN_RX,
      PBF_FN_TP,
      PBF_FN_OFF
   } pbf_fn_t;

   // Pin index 0..7 stands for port pin 8..15
   function automatic pbf_fn_t pbf_decode(input int pin,
                                          input logic [1:0] code);
      pbf_fn_t fn;
      fn = PBF_FN_OFF;
      unique case (code)
         PBF_CODE_GPIO: fn = PBF_FN_GPIO;
         PBF_CODE_ALT1:
            fn = (pin >= PBF_IRQ_BASE) ? PBF_FN_IRQ : PBF_FN_OFF;
         PBF_CODE_ALT2:
         begin
            if (pin >= PBF_RSV2_BASE)
               fn = PBF_FN_OFF;
            else if (pin >= PBF_IRQ_BASE)
               fn = PBF_FN_SCK;
            else if (pin % 2 == 1)
               fn = PBF_FN_TX;
            else
               fn = PBF_FN_RX;
         end
         PBF_CODE_TP: fn = PBF_FN_TP;
      endcase
      return fn;
   endfunction
endpackage

// ---- rtl/pbf_mux_if.sv ----
// Signals between the register side and the pin multiplexer
`timescale 1ns/1ps
interface pbf_mux_if;
   import pbf_pkg::*;
   logic [15:0] mode;
   logic [7:0] dir;
   logic [7:0] pin_lvl;
   logic [7:0] gpio_out;
   logic [1:0] sck_out;
   logic [1:0] tx;
   logic [7:0] tp;
   logic [7:0] drv;
   logic [7:0] en;
   logic [3:0] irq;
   logic [1:0] sck_in;
   logic [1:0] rx;
   modport ctrl
   (
      output mode, dir, pin_lvl, gpio_out, sck_out, tx, tp,
      input drv, en, irq, sck_in, rx
   );
   modport mux
   (
      input mode, dir, pin_lvl, gpio_out, sck_out, tx, tp,
      output drv, en, irq, sck_in, rx
   );
endinterface

// ---- rtl/pbf_pin_mux.sv ----
// Per-pin function multiplexer, purely combinational
`timescale 1ns/1ps
module pbf_pin_mux
   import pbf_pkg::*;
(
   pbf_mux_if.mux m
);
   pbf_fn_t fn [PBF_NPINS];

   genvar i;
   generate
      for (i = 0; i < PBF_NPINS; i++)
      begin : g_pin
         assign fn[i] = pbf_decode(i, m.mode[PBF_FIELD_W*i +: PBF_FIELD_W]);
         always_comb
         begin
            m.drv[i] = 1'b0;
            m.en[i] = 1'b0;
            unique case (fn[i])
               PBF_FN_GPIO:
               begin
                  m.en[i] = m.dir[i];
                  m.drv[i] = m.gpio_out[i];
               end
               PBF_FN_SCK:
               begin
                  m.en[i] = m.dir[i];
                  m.drv[i] = m.sck_out[i % 2];
               end
               PBF_FN_TX:
               begin
                  m.en[i] = 1'b1;
                  m.drv[i] = m.tx[i / 2];
               end
               PBF_FN_TP:
               begin
                  m.en[i] = 1'b1;
                  m.drv[i] = m.tp[i];
               end
               // Interrupt, receive and reserved codes leave the pin an input
               PBF_FN_IRQ, PBF_FN_RX, PBF_FN_OFF:
               begin
                  m.en[i] = 1'b0;
                  m.drv[i] = 1'b0;
               end
            endcase
         end
      end
      for (i = 0; i < PBF_NIRQ; i++)
      begin : g_irq
         // Unselected request lines idle high so no spurious request is seen
         assign m.irq[i] = (fn[i + PBF_IRQ_BASE] == PBF_FN_IRQ) ?
                           m.pin_lvl[i + PBF_IRQ_BASE] : 1'b1;
      end
      for (i = 0; i < PBF_NCH; i++)
      begin : g_ch
         assign m.sck_in[i] = (fn[i + PBF_IRQ_BASE] == PBF_FN_SCK) &&
                              !m.dir[i + PBF_IRQ_BASE] &&
                              m.pin_lvl[i + PBF_IRQ_BASE];
         // Receive idles at mark level when the pin is not routed
         assign m.rx[i] = (fn[2 * i] == PBF_FN_RX) ? m.pin_lvl[2 * i] : 1'b1;
      end
   endgenerate
endmodule

// ---- rtl/pbf_upper_pin_select.sv ----
// Port B upper function-select register and pin routing
//
// Behaviour
// - 16-bit read/write select register, two bits per pin, pin 15 on top.
// - Pin 15: 00 I/O, 01 interrupt 7, 10 reserved, 11 pattern 15.
// - Pin 14: 00 I/O, 01 interrupt 6, 10 reserved, 11 pattern 14.
// - Pin 13: 00 I/O, 01 interrupt 5, 10 serial clock 1, 11 pattern 13.
// - Pin 12: 00 I/O, 01 interrupt 4, 10 serial clock 0, 11 pattern 12.
// - Pin 11: 00 I/O, 01 reserved, 10 transmit 1, 11 pattern 11.
// - Pin 10: 00 I/O, 01 reserved, 10 receive 1, 11 pattern 10.
// - Pin 9: 00 I/O, 01 reserved, 10 transmit 0, 11 pattern 9.
// - Pin 8: 00 I/O, 01 reserved, 10 receive 0, 11 pattern 8.
// - Power-on reset clears the register; other resets keep it.
// - In I/O and serial clock modes, direction bit 1 drives, 0 inputs.
`timescale 1ns/1ps
module pbf_upper_pin_select
   import pbf_pkg::*;
#(
   parameter int AW = 4
)
(
   input wire logic MCLK_IN,
   input wire logic RST_B_IN,
   input wire logic [AW-1:0] ADDR_IN,
   input wire logic [15:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [15:0] RDATA_OUT,
   input wire logic [7:0] DIR_IN,
   input wire logic [7:0] GPIO_DATA_IN,
   output logic [7:0] GPIO_LEVEL_OUT,
   input wire logic [1:0] SCK_DRV_IN,
   output logic [1:0] SCK_IN_OUT,
   input wire logic [1:0] TX_IN,
   output logic [1:0] RX_OUT,
   input wire logic [7:0] TP_IN,
   output logic [3:0] EXT_IRQ_OUT,
   input wire logic [7:0] PIN_IN,
   output logic [7:0] PIN_OUT,
   output logic [7:0] PIN_OE_B_OUT
);
   generate
      if (AW < PBF_OFS_W)
      begin : g_chk
         $error("AW too narrow for the register offsets");
      end
   endgenerate

   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [3:0] ofs);
      return a == AW'(ofs);
   endfunction

   logic [15:0] mode_reg;
   logic [7:0] s1_reg;
   logic [7:0] s2_reg;
   logic [7:0] s3_reg;
   logic [7:0] lvl_reg;
   pbf_mux_if mif ();

   // Only the power-on reset reaches this register
   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_B_IN)
         mode_reg <= PBF_FSEL_RST;
      else if (WR_IN && hit(ADDR_IN, PBF_OFS_FSEL))
         mode_reg <= WDATA_IN;
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_B_IN)
         RDATA_OUT <= PBF_RDATA_RST;
      else if (RD_IN && hit(ADDR_IN, PBF_OFS_FSEL))
         RDATA_OUT <= mode_reg;
      else if (RD_IN && hit(ADDR_IN, PBF_OFS_LEVEL))
         RDATA_OUT <= {8'h00, lvl_reg};
      else
         RDATA_OUT <= PBF_RDATA_RST;
   end

   // Level accepted only once the second and third stages agree
   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_B_IN)
      begin
         s1_reg <= PBF_PIN_RST;
         s2_reg <= PBF_PIN_RST;
         s3_reg <= PBF_PIN_RST;
         lvl_reg <= PBF_PIN_RST;
      end
      else
      begin
         s1_reg <= PIN_IN;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int k = 0; k < PBF_NPINS; k++)
         begin
            if (s2_reg[k] == s3_reg[k])
               lvl_reg[k] <= s3_reg[k];
         end
      end
   end

   assign mif.mode = mode_reg;
   assign mif.dir = DIR_IN;
   assign mif.pin_lvl = lvl_reg;
   assign mif.gpio_out = GPIO_DATA_IN;
   assign mif.sck_out = SCK_DRV_IN;
   assign mif.tx = TX_IN;
   assign mif.tp = TP_IN;

   pbf_pin_mux u_mux
   (
      .m(mif.mux)
   );

   // Pin drive registered so every pin changes on a clock edge only
   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_B_IN)
      begin
         PIN_OUT <= PBF_PIN_RST;
         PIN_OE_B_OUT <= PBF_OE_B_RST;
      end
      else
      begin
         PIN_OUT <= mif.drv;
         PIN_OE_B_OUT <= ~mif.en;
      end
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_B_IN)
      begin
         EXT_IRQ_OUT <= PBF_IRQ_RST;
         RX_OUT <= PBF_RX_RST;
         SCK_IN_OUT <= PBF_SCK_RST;
         GPIO_LEVEL_OUT <= PBF_PIN_RST;
      end
      else
      begin
         EXT_IRQ_OUT <= mif.irq;
         RX_OUT <= mif.rx;
         SCK_IN_OUT <= mif.sck_in;
         GPIO_LEVEL_OUT <= lvl_reg;
      end
   end

   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   sequence s_wr_fsel;
      WR_IN && hit(ADDR_IN, PBF_OFS_FSEL);
   endsequence

   sequence s_wr_pattern_out_15;
      s_wr_fsel and (WDATA_IN[15:14] == PBF_CODE_TP);
   endsequence

   property p_fsel_write;
      s_wr_fsel |=> mode_reg == $past(WDATA_IN);
   endproperty
   a_fsel_write: assert property (p_fsel_write)
      else $error("select register did not take written value");

   property p_read_back;
      RD_IN && hit(ADDR_IN, PBF_OFS_FSEL) |=> RDATA_OUT == $past(mode_reg);
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("read data differs from select register");

   property p_pattern_out_15_path;
      s_wr_pattern_out_15 ##1 !WR_IN |=> !PIN_OE_B_OUT[7] &&
         PIN_OUT[7] == $past(TP_IN[7]);
   endproperty
   a_pattern_out_15_path: assert property (p_pattern_out_15_path)
      else $error("pin 15 not driving pattern after write");

   property p_rsv15;
      mode_reg[15:14] == PBF_CODE_ALT2 |=> PIN_OE_B_OUT[7] &&
         EXT_IRQ_OUT[3];
   endproperty
   a_rsv15: assert property (p_rsv15)
      else $error("reserved code on pin 15 drives the pin");

   property p_ext_interrupt_in_6;
      mode_reg[13:12] == PBF_CODE_ALT1 |=> PIN_OE_B_OUT[6] &&
         EXT_IRQ_OUT[2] == $past(lvl_reg[6]);
   endproperty
   a_ext_interrupt_in_6: assert property (p_ext_interrupt_in_6)
      else $error("pin 14 interrupt routing wrong");

   property p_serial_clock_ch1;
      mode_reg[11:10] == PBF_CODE_ALT2 |=>
         PIN_OE_B_OUT[5] == !$past(DIR_IN[5]) &&
         (PIN_OE_B_OUT[5] || PIN_OUT[5] == $past(SCK_DRV_IN[1]));
   endproperty
   a_serial_clock_ch1: assert property (p_serial_clock_ch1)
      else $error("pin 13 serial clock routing wrong");

   property p_serial_clock_ch0_in;
      mode_reg[9:8] == PBF_CODE_ALT2 && !DIR_IN[4] |=>
         PIN_OE_B_OUT[4] && SCK_IN_OUT[0] == $past(lvl_reg[4]);
   endproperty
   a_serial_clock_ch0_in: assert property (p_serial_clock_ch0_in)
      else $error("pin 12 serial clock input wrong");

   property p_tx1;
      mode_reg[7:6] == PBF_CODE_ALT2 |=> !PIN_OE_B_OUT[3] &&
         PIN_OUT[3] == $past(TX_IN[1]);
   endproperty
   a_tx1: assert property (p_tx1)
      else $error("pin 11 transmit routing wrong");

   property p_rx1;
      mode_reg[5:4] == PBF_CODE_ALT2 |=> PIN_OE_B_OUT[2] &&
         RX_OUT[1] == $past(lvl_reg[2]);
   endproperty
   a_rx1: assert property (p_rx1)
      else $error("pin 10 receive routing wrong");

   property p_tx0;
      mode_reg[3:2] == PBF_CODE_ALT2 |=> !PIN_OE_B_OUT[1] &&
         PIN_OUT[1] == $past(TX_IN[0]);
   endproperty
   a_tx0: assert property (p_tx0)
      else $error("pin 9 transmit routing wrong");

   property p_rx0;
      mode_reg[1:0] == PBF_CODE_ALT2 |=> PIN_OE_B_OUT[0] &&
         RX_OUT[0] == $past(lvl_reg[0]);
   endproperty
   a_rx0: assert property (p_rx0)
      else $error("pin 8 receive routing wrong");

   property p_gpio_dir;
      mode_reg[1:0] == PBF_CODE_GPIO |=>
         PIN_OE_B_OUT[0] == !$past(DIR_IN[0]) &&
         (PIN_OE_B_OUT[0] || PIN_OUT[0] == $past(GPIO_DATA_IN[0]));
   endproperty
   a_gpio_dir: assert property (p_gpio_dir)
      else $error("pin 8 general I/O direction wrong");

   property p_por_clear;
      @(posedge MCLK_IN) disable iff (1'b0)
      !RST_B_IN |=> mode_reg == PBF_FSEL_RST &&
         PIN_OE_B_OUT == PBF_OE_B_RST;
   endproperty
   a_por_clear: assert property (p_por_clear)
      else $error("reset did not clear select register");
endmodule

// ---- tb/pbf_pad_model.sv ----
// Behavioural model of the eight external pads of the upper port
`timescale 1ns/1ps
module pbf_pad_model
(
   input wire logic [7:0] pin_drv_in,
   input wire logic [7:0] pin_oe_b_in,
   input wire logic [7:0] ext_lvl_in,
   output logic [7:0] pin_lvl_out
);
   // Board drives a pad only where the device lets go
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         pin_lvl_out[i] = pin_oe_b_in[i] ? ext_lvl_in[i] : pin_drv_in[i];
   end
endmodule

// ---- tb/pbf_upper_pin_select_tb.sv ----
// Self-checking bench for the upper port pin function select
`timescale 1ns/1ps
module pbf_upper_pin_select_tb;
   import pbf_pkg::*;
   logic MCLK_IN = 1'b0;
   logic RST_B_IN;
   logic [3:0] ADDR_IN;
   logic [15:0] WDATA_IN, RDATA_OUT, rv;
   logic WR_IN, RD_IN;
   logic [7:0] DIR_IN, GPIO_DATA_IN, GPIO_LEVEL_OUT, TP_IN, PIN_IN;
   logic [7:0] PIN_OUT, PIN_OE_B_OUT, ext_lvl;
   logic [1:0] SCK_DRV_IN, SCK_IN_OUT, TX_IN, RX_OUT;
   logic [3:0] EXT_IRQ_OUT;
   integer seed;
   int n_mismatch = 0;
   int n_compared = 0;

   pbf_upper_pin_select #(.AW(4)) uut
   (
      .MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN),
      .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
      .RDATA_OUT(RDATA_OUT), .DIR_IN(DIR_IN), .GPIO_DATA_IN(GPIO_DATA_IN),
      .GPIO_LEVEL_OUT(GPIO_LEVEL_OUT), .SCK_DRV_IN(SCK_DRV_IN),
      .SCK_IN_OUT(SCK_IN_OUT), .TX_IN(TX_IN), .RX_OUT(RX_OUT),
      .TP_IN(TP_IN), .EXT_IRQ_OUT(EXT_IRQ_OUT), .PIN_IN(PIN_IN),
      .PIN_OUT(PIN_OUT), .PIN_OE_B_OUT(PIN_OE_B_OUT)
   );

   pbf_pad_model pads
   (
      .pin_drv_in(PIN_OUT), .pin_oe_b_in(PIN_OE_B_OUT),
      .ext_lvl_in(ext_lvl), .pin_lvl_out(PIN_IN)
   );

   always #25 MCLK_IN = ~MCLK_IN;

   task automatic final_report;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] s);
      n_compared++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic chk_pin(input string nm, input logic [7:0] e,
                          input logic [7:0] s);
      chk(nm, {8'h00, e}, {8'h00, s});
   endtask

   task automatic chk_per(input string nm, input logic [7:0] e,
                          input logic [7:0] s);
      chk(nm, {8'h00, e}, {8'h00, s});
   endtask

   // Entered and left on a rising edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      ADDR_IN <= a;
      WDATA_IN <= d;
      WR_IN <= 1'b1;
      @(posedge MCLK_IN);
      WR_IN <= 1'b0;
      // Gap edge so a following write never re-raises the strobe at once
      @(posedge MCLK_IN);
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      ADDR_IN <= a;
      RD_IN <= 1'b1;
      @(posedge MCLK_IN);
      RD_IN <= 1'b0;
      @(negedge MCLK_IN);
      d = RDATA_OUT;
      @(negedge MCLK_IN);
      chk("rdata_idle", 16'h0000, RDATA_OUT);
      @(posedge MCLK_IN);
   endtask

   // Returns {active-low enables, drive values}
   function automatic logic [15:0] exp_pin(input logic [15:0] m,
      input logic [7:0] d, g, tp, input logic [1:0] sk, tx);
      logic [7:0] oe, dv;
      logic [1:0] c;
      oe = 8'hFF;
      dv = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         c = m[2*i+:2];
         if (c == 2'h0)
            {oe[i], dv[i]} = {~d[i], g[i]};
         else if (c == 2'h3)
            {oe[i], dv[i]} = {1'b0, tp[i]};
         else if (c == 2'h2 && (i == 4 || i == 5))
            {oe[i], dv[i]} = {~d[i], sk[i-4]};
         else if (c == 2'h2 && (i == 1 || i == 3))
            {oe[i], dv[i]} = {1'b0, tx[i/2]};
      end
      return {oe, dv};
   endfunction

   // Returns {irq 7..4, rx 1..0, sck in 1..0}
   function automatic logic [7:0] exp_per(input logic [15:0] m,
      input logic [7:0] d, lv);
      logic [7:0] r;
      r = 8'hFC;
      for (int k = 0; k < 4; k++)
         if (m[2*(4+k)+:2] == 2'h1)
            r[4+k] = lv[4+k];
      if (m[1:0] == 2'h2)
         r[2] = lv[0];
      if (m[5:4] == 2'h2)
         r[3] = lv[2];
      for (int k = 0; k < 2; k++)
         if (m[2*(4+k)+:2] == 2'h2 && !d[4+k])
            r[k] = lv[4+k];
      return r;
   endfunction

   // Reserved codes are swapped for general I/O
   function automatic logic [15:0] legal(input logic [15:0] m);
      for (int i = 0; i < 8; i++)
         if ((i >= 6 && m[2*i+:2] == 2'h2) || (i < 4 && m[2*i+:2] == 2'h1))
            m[2*i+:2] = 2'h0;
      return m;
   endfunction

   task automatic run_case(input logic [15:0] m);
      logic [15:0] p;
      logic [7:0] lv;
      wr(PBF_OFS_FSEL, m);
      rd(PBF_OFS_FSEL, rv);
      chk("fsel", m, rv);
      DIR_IN <= 8'($random(seed));
      GPIO_DATA_IN <= 8'($random(seed));
      TP_IN <= 8'($random(seed));
      SCK_DRV_IN <= 2'($random(seed));
      TX_IN <= 2'($random(seed));
      ext_lvl <= 8'($random(seed));
      repeat (10) @(posedge MCLK_IN);
      @(negedge MCLK_IN);
      p = exp_pin(m, DIR_IN, GPIO_DATA_IN, TP_IN, SCK_DRV_IN, TX_IN);
      lv = (ext_lvl & p[15:8]) | (p[7:0] & ~p[15:8]);
      chk_pin("oe_b", p[15:8], PIN_OE_B_OUT);
      chk_pin("pin", p[7:0] & ~p[15:8],
              PIN_OUT & ~p[15:8]);
      chk_per("periph", exp_per(m, DIR_IN, lv),
              {EXT_IRQ_OUT, RX_OUT, SCK_IN_OUT});
      chk_pin("gpio_lvl", lv, GPIO_LEVEL_OUT);
      @(posedge MCLK_IN);
      rd(PBF_OFS_LEVEL, rv);
      chk("level", {8'h00, lv}, rv);
   endtask

   initial
   begin
      #(50 * 6000);
      n_mismatch++;
      final_report();
   end

   initial
   begin
      seed = 32'h76630A61;
      {ADDR_IN, WDATA_IN, WR_IN, RD_IN, DIR_IN, GPIO_DATA_IN} = '0;
      {TP_IN, SCK_DRV_IN, TX_IN, ext_lvl} = '0;
      RST_B_IN = 1'b0;
      repeat (5) @(posedge MCLK_IN);
      @(negedge MCLK_IN);
      chk_pin("rst_pins", 8'hFF, PIN_OE_B_OUT);
      chk_pin("rst_drv", 8'h00, PIN_OUT);
      chk_pin("rst_lvl", 8'h00, GPIO_LEVEL_OUT);
      chk_per("rst_per", 8'hFC, {EXT_IRQ_OUT, RX_OUT, SCK_IN_OUT});
      @(posedge MCLK_IN);
      RST_B_IN <= 1'b1;
      rd(PBF_OFS_FSEL, rv);
      chk("fsel_rst", 16'h0000, rv);
      // Every code in every field, reserved ones included
      for (int c = 0; c < 4; c++)
         run_case({8{c[1:0]}});
      repeat (40) run_case(legal(16'($random(seed))));
      wr(PBF_OFS_FSEL, 16'hF0F0);
      wr(4'h4, 16'hFFFF);
      wr(PBF_OFS_LEVEL, 16'hFFFF);
      rd(PBF_OFS_FSEL, rv);
      chk("fsel_keep", 16'hF0F0, rv);
      rd(4'h4, rv);
      chk("unmapped", 16'h0000, rv);
      RST_B_IN <= 1'b0;
      repeat (4) @(posedge MCLK_IN);
      RST_B_IN <= 1'b1;
      rd(PBF_OFS_FSEL, rv);
      chk("fsel_rst2", 16'h0000, rv);
      final_report();
   end
endmodule
